// ---- design/audio_port_pkg.sv ----
`default_nettype none
package audio_port_pkg;

  // ----------------------------------------------------------------
  // Setup word layout
  // ----------------------------------------------------------------
  localparam int                 SETUP_W       = 24;
  localparam logic [SETUP_W-1:0] SETUP_RESET   = 24'h000000;
  localparam int                 F_FRAME_IIS   = 11;
  localparam int                 F_FRAME_POL   = 10;
  localparam int                 F_EDGE_RISE   = 9;
  localparam int                 F_IN_ORDER    = 8;
  localparam int                 F_IN_TRUNC    = 7;
  localparam int                 F_IN_LEN      = 5;
  localparam int                 F_OUT_ORDER   = 4;
  localparam int                 F_OUT_TRUNC   = 3;
  localparam int                 F_OUT_LEN     = 1;

  // ----------------------------------------------------------------
  // Word lengths and slot widths
  // ----------------------------------------------------------------
  localparam int         SAMPLE_W = 24;
  localparam logic [1:0] LEN_16   = 2'h0;
  localparam logic [1:0] LEN_18   = 2'h1;
  localparam logic [1:0] LEN_20   = 2'h2;
  localparam logic [5:0] WORD_16  = 6'h10;
  localparam logic [5:0] WORD_18  = 6'h12;
  localparam logic [5:0] WORD_20  = 6'h14;
  localparam logic [5:0] WORD_24  = 6'h18;
  localparam logic [5:0] SLOT_24  = 6'h18;
  localparam logic [5:0] SLOT_32  = 6'h20;
  localparam logic [5:0] CNT_MAX  = 6'h3f;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_SYS_HZ     = 250_000_000;
  localparam int         FS_HZ          = 44_100;
  localparam int         MCLK_PER_FS    = 768;
  localparam int         BCK_PER_FS     = 64;
  localparam int         MCLK_PER_BCK   = MCLK_PER_FS / BCK_PER_FS;
  localparam int         BCK_HZ         = MCLK_PER_FS * FS_HZ / MCLK_PER_BCK;
  localparam int         BCK_HALF_CYC   = CLK_SYS_HZ / (BCK_HZ * 2);
  localparam int         DIV_W          = 8;
  localparam logic [4:0] HALF_FRAME_M1  = 5'h1f;
  localparam logic [1:0] WIN_RISE_COUNT = 2'h2;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } sample_pair_s;

  typedef struct packed {
    logic       lsb_first;
    logic       rear_trunc;
    logic [1:0] len;
  } dir_fmt_s;

  typedef struct packed {
    logic mss;
    logic s24;
    logic win_n;
    logic rst_n;
    logic bclk;
    logic frame_clock;
    logic sdin;
  } pins_s;

  function automatic logic [5:0] word_bits(input logic [1:0] len);
    case (len)
      LEN_16:  word_bits = WORD_16;
      LEN_18:  word_bits = WORD_18;
      LEN_20:  word_bits = WORD_20;
      default: word_bits = WORD_24;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- design/audio_serial_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module audio_serial_port
  import audio_port_pkg::*;
#(
  parameter int BCK_HALF   = audio_port_pkg::BCK_HALF_CYC,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  // Mode and control pins
  input  wire logic                               master_slave_select,
  input  wire logic                               slot_width_select,
  input  wire logic                               sync_window_n,
  input  wire logic                               system_reset_n,
  // Bit clock pin
  input  wire logic                               bit_clock_i,
  output logic                                    bit_clock_o,
  output logic                                    bit_clock_oe_n,
  // Frame clock pin
  input  wire logic                               frame_clock_i,
  output logic                                    frame_clock_o,
  output logic                                    frame_clock_oe_n,
  // Serial data pins
  input  wire logic                               serial_audio_in,
  output logic                                    serial_audio_out,
  // Setup word load
  input  wire logic [audio_port_pkg::SETUP_W-1:0] setup_word,
  input  wire logic                               setup_load,
  // Samples to send
  input  wire logic                               tx_valid,
  input  wire audio_port_pkg::sample_pair_s       tx_pair,
  output logic                                    tx_ready,
  // Samples received
  output logic                                    rx_valid,
  output audio_port_pkg::sample_pair_s            rx_pair,
  // Status
  output logic                                    frame_locked,
  output logic                                    setup_valid
);
  import audio_port_pkg::*;

  // ----------------------------------------------------------------
  // Slot helpers
  // ----------------------------------------------------------------
  // Returns {bit belongs to previous channel, bit position in slot}.
  function automatic logic [6:0] slot_pos(input logic [5:0] cnt, input logic iis,
                                          input logic [5:0] slot);
    if (!iis)
      slot_pos = {1'b0, cnt};
    else if (cnt == 6'h00)
      slot_pos = {1'b1, 6'(slot - 6'h01)};
    else
      slot_pos = {1'b0, 6'(cnt - 6'h01)};
  endfunction

  // Returns {bit carries data, index into the left-justified sample}.
  function automatic logic [5:0] bit_map(input logic [5:0] pos, input dir_fmt_s f,
                                         input logic [5:0] slot);
    logic [5:0] w;
    logic [5:0] off;
    logic [5:0] p;
    w   = word_bits(f.len);
    off = (f.rear_trunc && !(slot == SLOT_24 && w == WORD_24)) ? 6'(slot - w) : 6'h00;
    p   = 6'(pos - off);
    bit_map = 6'h00;
    if (pos >= off && p < w)
      bit_map = {1'b1, f.lsb_first ? 5'(WORD_24 - w + p) : 5'(WORD_24 - 6'h01 - p)};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pins_s meta_ff;
  pins_s pin_ff;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= '{mss: 1'b1, s24: 1'b1, win_n: 1'b1, rst_n: 1'b0, default: 1'b0};
      pin_ff  <= '{mss: 1'b1, s24: 1'b1, win_n: 1'b1, rst_n: 1'b0, default: 1'b0};
    end
    else
    begin
      meta_ff <= '{mss: master_slave_select, s24: slot_width_select,
                   win_n: sync_window_n, rst_n: system_reset_n, bclk: bit_clock_i,
                   frame_clock: frame_clock_i, sdin: serial_audio_in};
      pin_ff  <= meta_ff;
    end
  end

  logic       master;
  logic       port_rst;
  logic [5:0] slot;

  assign master   = ~pin_ff.mss;
  assign port_rst = ~pin_ff.rst_n;
  assign slot     = (master | pin_ff.s24) ? SLOT_32 : SLOT_24;

  // ----------------------------------------------------------------
  // Setup register
  // ----------------------------------------------------------------
  logic [SETUP_W-1:0] setup_ff;
  logic [SETUP_W-1:0] nxt_setup;
  logic               setup_valid_ff;
  logic               nxt_setup_valid;
  dir_fmt_s           in_fmt;
  dir_fmt_s           out_fmt;
  logic               iis;
  logic               left_low;
  logic               edge_rise;

  always_comb
  begin
    nxt_setup       = setup_ff;
    nxt_setup_valid = setup_valid_ff & ~port_rst;
    if (setup_load)
    begin
      nxt_setup       = setup_word;
      nxt_setup_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_ff       <= SETUP_RESET;
      setup_valid_ff <= 1'b0;
    end
    else
    begin
      setup_ff       <= nxt_setup;
      setup_valid_ff <= nxt_setup_valid;
    end
  end

  assign iis       = setup_ff[F_FRAME_IIS];
  assign left_low  = setup_ff[F_FRAME_POL];
  assign edge_rise = setup_ff[F_EDGE_RISE];
  assign in_fmt    = {setup_ff[F_IN_ORDER], setup_ff[F_IN_TRUNC],
                      setup_ff[F_IN_LEN+1:F_IN_LEN]};
  assign out_fmt   = {setup_ff[F_OUT_ORDER], setup_ff[F_OUT_TRUNC],
                      setup_ff[F_OUT_LEN+1:F_OUT_LEN]};

  // ----------------------------------------------------------------
  // Master clock generation
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic             mbclk_ff;
  logic             nxt_mbclk;
  logic             mlrck_ff;
  logic             nxt_mlrck;
  logic [4:0]       mbit_ff;
  logic [4:0]       nxt_mbit;
  logic             force_sync;

  always_comb
  begin
    nxt_div   = DIV_W'(div_ff + 1'b1);
    nxt_mbclk = mbclk_ff;
    nxt_mlrck = mlrck_ff;
    nxt_mbit  = mbit_ff;
    if (port_rst || force_sync || !master)
    begin
      nxt_div   = '0;
      nxt_mbclk = ~edge_rise;
      nxt_mlrck = 1'b0;
      nxt_mbit  = '0;
    end
    else if (div_ff == DIV_W'(BCK_HALF - 1))
    begin
      nxt_div   = '0;
      nxt_mbclk = ~mbclk_ff;
      if (~mbclk_ff == edge_rise)
      begin
        nxt_mbit = 5'(mbit_ff + 1'b1);
        if (mbit_ff == HALF_FRAME_M1)
          nxt_mlrck = ~mlrck_ff;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      div_ff   <= '0;
      mbclk_ff <= 1'b0;
      mlrck_ff <= 1'b0;
      mbit_ff  <= '0;
    end
    else
    begin
      div_ff   <= nxt_div;
      mbclk_ff <= nxt_mbclk;
      mlrck_ff <= nxt_mlrck;
      mbit_ff  <= nxt_mbit;
    end
  end

  assign bit_clock_o      = mbclk_ff;
  assign frame_clock_o    = mlrck_ff;
  assign bit_clock_oe_n   = ~master;
  assign frame_clock_oe_n = ~master;

  // ----------------------------------------------------------------
  // Edge tracking, slot counter and forced synchronisation
  // ----------------------------------------------------------------
  logic       bclk;
  logic       frame_clock;
  logic       bclk_d_ff;
  logic       frame_clock_d_ff;
  logic       cap;
  logic       launch;
  logic       lr_chg;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic       chan_ff;
  logic       nxt_chan;
  logic       prev_chan_ff;
  logic       nxt_prev_chan;
  logic       locked_ff;
  logic       nxt_locked;
  logic       win_arm_ff;
  logic       nxt_win_arm;
  logic [1:0] win_rise_ff;
  logic [1:0] nxt_win_rise;

  assign bclk   = master ? mbclk_ff : pin_ff.bclk;
  assign frame_clock   = master ? mlrck_ff : pin_ff.frame_clock;
  assign cap    = edge_rise ? (bclk_d_ff & ~bclk) : (bclk & ~bclk_d_ff);
  assign launch = edge_rise ? (bclk & ~bclk_d_ff) : (bclk_d_ff & ~bclk);
  assign lr_chg = frame_clock ^ frame_clock_d_ff;
  assign force_sync = win_arm_ff & frame_clock & ~frame_clock_d_ff
                    & (win_rise_ff == WIN_RISE_COUNT - 2'h1);

  always_comb
  begin
    nxt_cnt       = cnt_ff;
    nxt_chan      = chan_ff;
    nxt_prev_chan = prev_chan_ff;
    nxt_locked    = locked_ff;
    nxt_win_arm   = ~pin_ff.win_n;
    nxt_win_rise  = win_rise_ff;
    if (!win_arm_ff)
      nxt_win_rise = 2'h0;
    else if (frame_clock && !frame_clock_d_ff && win_rise_ff != WIN_RISE_COUNT)
      nxt_win_rise = 2'(win_rise_ff + 1'b1);
    if (port_rst)
    begin
      nxt_cnt      = 6'h00;
      nxt_locked   = 1'b0;
      nxt_win_arm  = 1'b0;
    end
    else if (lr_chg || force_sync)
    begin
      nxt_cnt       = 6'h00;
      nxt_prev_chan = chan_ff;
      nxt_chan      = frame_clock ^ left_low;
      nxt_locked    = 1'b1;
    end
    else if (cap && cnt_ff != CNT_MAX)
      nxt_cnt = 6'(cnt_ff + 1'b1);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      bclk_d_ff    <= 1'b0;
      frame_clock_d_ff    <= 1'b0;
      cnt_ff       <= 6'h00;
      chan_ff      <= 1'b1;
      prev_chan_ff <= 1'b0;
      locked_ff    <= 1'b0;
      win_arm_ff   <= 1'b0;
      win_rise_ff  <= 2'h0;
    end
    else
    begin
      bclk_d_ff    <= bclk;
      frame_clock_d_ff    <= frame_clock;
      cnt_ff       <= nxt_cnt;
      chan_ff      <= nxt_chan;
      prev_chan_ff <= nxt_prev_chan;
      locked_ff    <= nxt_locked;
      win_arm_ff   <= nxt_win_arm;
      win_rise_ff  <= nxt_win_rise;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  sample_pair_s acc_ff;
  sample_pair_s nxt_acc;
  sample_pair_s rx_pair_ff;
  sample_pair_s nxt_rx_pair;
  logic         rx_valid_ff;
  logic         nxt_rx_valid;
  sample_pair_s tx_cur_ff;
  sample_pair_s nxt_tx_cur;
  sample_pair_s tx_prev_ff;
  sample_pair_s nxt_tx_prev;
  logic         dout_ff;
  logic         nxt_dout;
  logic         active;
  logic         fifo_rd_valid;
  logic         fifo_rd_ready;
  sample_pair_s fifo_rd_data;
  logic [6:0]   sp;
  logic [5:0]   in_map;
  logic [5:0]   out_map;
  logic         rx_left;
  logic         tx_left;
  logic [SAMPLE_W-1:0] tx_word;
  logic [5:0]   edge_map;
  logic [SAMPLE_W-1:0] edge_word;

  assign active        = locked_ff & setup_valid_ff & ~port_rst;
  assign fifo_rd_ready = active & lr_chg & (frame_clock ^ left_low);

  always_comb
  begin
    nxt_acc      = acc_ff;
    nxt_rx_pair  = rx_pair_ff;
    nxt_rx_valid = 1'b0;
    nxt_tx_cur   = tx_cur_ff;
    nxt_tx_prev  = tx_prev_ff;
    nxt_dout     = dout_ff;
    sp           = slot_pos(cnt_ff, iis, slot);
    rx_left      = sp[6] ? prev_chan_ff : chan_ff;
    in_map       = bit_map(sp[5:0], in_fmt, slot);
    out_map      = bit_map(sp[5:0], out_fmt, slot);
    tx_left      = rx_left;
    edge_map     = bit_map(6'h00, out_fmt, slot);
    edge_word    = tx_cur_ff.right;
    if (frame_clock ^ left_low)
      edge_word = fifo_rd_valid ? fifo_rd_data.left : '0;
    if (sp[6])
      tx_word = chan_ff ? tx_prev_ff.right : tx_cur_ff.left;
    else
      tx_word = tx_left ? tx_cur_ff.left : tx_cur_ff.right;
    if (cap && active)
    begin
      if (in_map[5] && rx_left)
        nxt_acc.left[in_map[4:0]] = pin_ff.sdin;
      else if (in_map[5])
        nxt_acc.right[in_map[4:0]] = pin_ff.sdin;
      if (!rx_left && sp[5:0] == 6'(slot - 6'h01))
      begin
        nxt_rx_pair  = nxt_acc;
        nxt_rx_valid = 1'b1;
        nxt_acc      = '0;
      end
    end
    if (fifo_rd_ready)
    begin
      nxt_tx_prev = tx_cur_ff;
      nxt_tx_cur  = fifo_rd_valid ? fifo_rd_data : '0;
    end
    if (launch || lr_chg)
      nxt_dout = active & out_map[5] & tx_word[out_map[4:0]];
    // In normal framing the first slot bit leaves on the frame edge itself, before the
    // slot counter has restarted, so it is taken from the new channel's word here.
    if (lr_chg && !iis)
      nxt_dout = active & edge_map[5] & edge_word[edge_map[4:0]];
    if (port_rst)
    begin
      nxt_acc    = '0;
      nxt_tx_cur = '0;
      nxt_dout   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_ff      <= '0;
      rx_pair_ff  <= '0;
      rx_valid_ff <= 1'b0;
      tx_cur_ff   <= '0;
      tx_prev_ff  <= '0;
      dout_ff     <= 1'b0;
    end
    else
    begin
      acc_ff      <= nxt_acc;
      rx_pair_ff  <= nxt_rx_pair;
      rx_valid_ff <= nxt_rx_valid;
      tx_cur_ff   <= nxt_tx_cur;
      tx_prev_ff  <= nxt_tx_prev;
      dout_ff     <= nxt_dout;
    end
  end

  // Samples wait here until a left slot begins; a full buffer stalls the source.
  sample_fifo #(
    .WIDTH ($bits(sample_pair_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .wr_valid (tx_valid),
    .wr_data  (tx_pair),
    .wr_ready (tx_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rd_ready (fifo_rd_ready)
  );

  assign serial_audio_out = dout_ff;
  assign rx_valid         = rx_valid_ff;
  assign rx_pair          = rx_pair_ff;
  assign frame_locked     = locked_ff;
  assign setup_valid      = setup_valid_ff;

endmodule // audio_serial_port
`default_nettype wire

// ---- design/sample_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  // Drain side
  output logic                  rd_valid,
  output logic      [WIDTH-1:0] rd_data,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic [AW-1:0]    nxt_wp;
  logic [AW-1:0]    nxt_rp;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign wr_ready = cnt_ff != (AW+1)'(DEPTH);
  assign rd_valid = cnt_ff != '0;
  assign rd_data  = mem[rp_ff];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_comb
  begin
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push)
      nxt_wp = (wp_ff == AW'(DEPTH - 1)) ? '0 : AW'(wp_ff + 1'b1);
    if (pop)
      nxt_rp = (rp_ff == AW'(DEPTH - 1)) ? '0 : AW'(rp_ff + 1'b1);
    if (push && !pop)
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    else if (pop && !push)
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_ff] <= wr_data;
  end

endmodule // sample_fifo
`default_nettype wire

// ---- dv/audio_partner_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module audio_partner_model (
  // Bench control
  input  wire logic       run,
  input  wire logic       edge_rise,
  input  wire logic [5:0] half_bits,
  // Link pins
  input  wire logic       sdo_dev,
  output logic            bclk,
  output logic            frame_clock,
  output logic            sdi_dev
);
  int cnt = 0;

  // The far end echoes the device's output, so each frame sent comes back as input.
  assign sdi_dev = sdo_dev;

  // Both clocks come from one generator and stand still between runs.
  initial
  begin
    bclk = 1'b1;
    frame_clock = 1'b0;
    forever
    begin
      if (!run)
      begin
        wait (run);
        #1.3;
      end
      #80 bclk = edge_rise;
      cnt++;
      if (cnt >= half_bits)
      begin
        frame_clock = ~frame_clock;
        cnt = 0;
      end
      #80 bclk = ~edge_rise;
    end
  end
endmodule // audio_partner_model
`default_nettype wire

// ---- dv/audio_serial_port_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module audio_serial_port_checker #(
  parameter int BCK_HALF = 4
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Pins
  input  wire logic master_slave_select,
  input  wire logic system_reset_n,
  input  wire logic bit_clock_o,
  input  wire logic bit_clock_oe_n,
  input  wire logic frame_clock_o,
  input  wire logic frame_clock_oe_n,
  input  wire logic serial_audio_out,
  // Setup, streams and status
  input  wire logic setup_load,
  input  wire logic setup_valid,
  input  wire logic frame_locked,
  input  wire logic tx_valid,
  input  wire logic tx_ready,
  input  wire logic rx_valid
);
  logic       bclk_q_ff;
  logic       fclk_q_ff;
  logic [7:0] half_ff;
  logic [7:0] nbit_ff;
  logic [1:0] nfr_ff;
  logic       bchg;
  logic       fchg;
  logic       mst;

  assign bchg = bit_clock_o ^ bclk_q_ff;
  assign fchg = frame_clock_o ^ fclk_q_ff;
  assign mst  = !bit_clock_oe_n && system_reset_n;

  // Periods are judged only after three frame changes, so a restarting divider is not flagged.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      bclk_q_ff <= 1'b0;
      fclk_q_ff <= 1'b0;
      half_ff   <= 8'h00;
      nbit_ff   <= 8'h00;
      nfr_ff    <= 2'h0;
    end
    else
    begin
      bclk_q_ff <= bit_clock_o;
      fclk_q_ff <= frame_clock_o;
      half_ff   <= bchg ? 8'h01 : half_ff + 8'h01;
      nbit_ff   <= fchg ? 8'h00 : nbit_ff + {7'h00, bchg};
      nfr_ff    <= !mst ? 2'h0 : nfr_ff + {1'b0, fchg && nfr_ff != 2'h3};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_setup_take; system_reset_n[*4] ##0 setup_load |=> setup_valid; endproperty
  a_setup_take: assert property (p_setup_take) else $error("setup not taken");
  property p_out_quiet; (!setup_valid)[*3] |-> !serial_audio_out; endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output not quiet");
  property p_master_drv; (!master_slave_select)[*5] |-> !bit_clock_oe_n && !frame_clock_oe_n; endproperty
  a_master_drv: assert property (p_master_drv) else $error("master not driving");
  property p_slave_rel; master_slave_select[*5] |-> bit_clock_oe_n && frame_clock_oe_n; endproperty
  a_slave_rel: assert property (p_slave_rel) else $error("slave driving clocks");
  property p_half; mst && bchg && nfr_ff == 2'h3 |-> half_ff == BCK_HALF; endproperty
  a_half: assert property (p_half) else $error("bit clock half period");
  property p_frame; mst && fchg && nfr_ff == 2'h3 |-> nbit_ff + bchg == 64; endproperty
  a_frame: assert property (p_frame) else $error("bit clocks per frame");
  property p_rx_pulse; rx_valid |=> (!rx_valid)[*8]; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse spacing");
  property p_fifo_fall; $fell(tx_ready) |-> $past(tx_valid); endproperty
  a_fifo_fall: assert property (p_fifo_fall) else $error("tx_ready fell unpushed");
  property p_clear; (!system_reset_n)[*5] |-> !setup_valid && !frame_locked; endproperty
  a_clear: assert property (p_clear) else $error("system reset not clearing");

  c_rx: cover property (rx_valid);
  c_full: cover property ($fell(tx_ready));
  c_lock: cover property ($rose(frame_locked));
endmodule // audio_serial_port_checker
`default_nettype wire

// ---- dv/audio_serial_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module audio_serial_port_tb_top;
  import audio_port_pkg::*;
  localparam int BH = 4;
  localparam int FR = 1920;
  logic         clk_sys = 1'b0;
  logic         rstn = 1'b0;
  logic         master_slave_select = 1'b1;
  logic         slot_width_select = 1'b1;
  logic         sync_window_n = 1'b1;
  logic         system_reset_n = 1'b1;
  logic         setup_load = 1'b0;
  logic         tx_valid = 1'b0;
  logic         run = 1'b0;
  logic [23:0]  setup_word = 24'h000000;
  sample_pair_s tx_pair = '0;
  sample_pair_s rx_pair;
  logic         bco, bcoe, fco, fcoe, sao, sai, txr, rxv, lck, sv, pbc, plr;
  logic [47:0]  rxq[$];
  int           n_mismatch = 0;
  int           check_count = 0;
  logic [23:0]  cfg[5] = '{24'h0000ee, 24'h0001f6, 24'h000e66, 24'h000088, 24'h0000cc};
  logic [47:0]  msk[5] = '{'1, '1, '1, 48'hffff00ffff00, 48'hfffff0fffff0};

  always #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (rxv === 1'b1)
      rxq.push_back(rx_pair);

  audio_serial_port #(.BCK_HALF(BH), .FIFO_DEPTH(32)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .master_slave_select(master_slave_select),
    .slot_width_select(slot_width_select), .sync_window_n(sync_window_n),
    .system_reset_n(system_reset_n), .bit_clock_i(bcoe ? pbc : bco), .bit_clock_o(bco),
    .bit_clock_oe_n(bcoe), .frame_clock_i(fcoe ? plr : fco), .frame_clock_o(fco),
    .frame_clock_oe_n(fcoe), .serial_audio_in(sai), .serial_audio_out(sao),
    .setup_word(setup_word), .setup_load(setup_load), .tx_valid(tx_valid),
    .tx_pair(tx_pair), .tx_ready(txr), .rx_valid(rxv), .rx_pair(rx_pair),
    .frame_locked(lck), .setup_valid(sv));

  audio_partner_model i_far (.run(run), .edge_rise(setup_word[9]),
    .half_bits(slot_width_select ? 6'h20 : 6'h18), .sdo_dev(sao), .bclk(pbc),
    .frame_clock(plr), .sdi_dev(sai));

  function automatic logic [47:0] pv(input int i);
    return {i[7:0], 16'hb4e1, 16'h3c96, i[7:0]};
  endfunction

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic load(input logic [23:0] w);
    @(posedge clk_sys);
    setup_word <= w;
    setup_load <= 1'b1;
    @(posedge clk_sys);
    setup_load <= 1'b0;
    #1 chk("setup_valid", 48'h1, {47'h0, sv});
  endtask

  task automatic fill(input int b, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_pair <= pv(b + i);
    end
    @(posedge clk_sys);
    tx_valid <= 1'b0;
  endtask

  // The first pair may fall in a frame cut short by a restart, so matching starts at b.
  task automatic expect_rx(input int b, input int n, input logic [47:0] m);
    int k;
    k = 0;
    while (k < rxq.size() && (rxq[k] & m) !== (pv(b) & m))
      k++;
    for (int i = 0; i < n; i++)
      chk("rx_pair", pv(b + i) & m, rxq[k + i] & m);
    rxq.delete();
  endtask

  task automatic run_cfg(input logic [23:0] w, input logic [47:0] m, input int b);
    load(w);
    fill(b, 4);
    run <= 1'b1;
    repeat (6 * FR) @(posedge clk_sys);
    run <= 1'b0;
    expect_rx(b + 1, 3, m);
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (95000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 chk("oe_n reset", 48'h1, {47'h0, bcoe & fcoe});
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1 chk("idle", 48'h0, {45'h0, sv, lck, sao});
    load(24'h000066);
    fill(0, 32);
    #1 chk("tx_ready full", 48'h0, {47'h0, txr});
    @(posedge clk_sys);
    master_slave_select <= 1'b0;
    repeat (36 * 128 * BH) @(posedge clk_sys);
    #1 chk("oe_n master", 48'h0, {47'h0, bcoe | fcoe});
    chk("tx_ready drained", 48'h1, {47'h0, txr});
    expect_rx(1, 31, '1);
    @(posedge clk_sys);
    master_slave_select <= 1'b1;
    slot_width_select <= 1'b0;
    for (int c = 0; c < 5; c++)
      run_cfg(cfg[c], msk[c], 40 + 4 * c);
    @(posedge clk_sys);
    system_reset_n <= 1'b0;
    repeat (FR) @(posedge clk_sys);
    #1 chk("system reset", 48'h0, {45'h0, sv, lck, sao});
    @(posedge clk_sys);
    system_reset_n <= 1'b1;
    sync_window_n <= 1'b0;
    run <= 1'b1;
    repeat (3 * FR) @(posedge clk_sys);
    #1 chk("frame_locked", 48'h1, {47'h0, lck});
    test_done();
  end
endmodule // audio_serial_port_tb_top

bind audio_serial_port audio_serial_port_checker #(.BCK_HALF(BCK_HALF)) i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .master_slave_select(master_slave_select),
  .system_reset_n(system_reset_n), .bit_clock_o(bit_clock_o),
  .bit_clock_oe_n(bit_clock_oe_n), .frame_clock_o(frame_clock_o),
  .frame_clock_oe_n(frame_clock_oe_n), .serial_audio_out(serial_audio_out),
  .setup_load(setup_load), .setup_valid(setup_valid), .frame_locked(frame_locked),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid));
`default_nettype wire
